// File: calib_params.svh
`ifndef CALIB_PARAMS_SVH
`define CALIB_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_TIP_GAIN_MISMATCH     8'h63
`define OFS_DIFF_DAC_GAIN         8'h64
`define OFS_CM_DAC_GAIN           8'h65
`define OFS_CURRENT_LIMIT_CAL     8'h66
`define OFS_MONITOR_ADC_OFFSET    8'h67
`define OFS_ANALOG_OFFSET_TRIM    8'h68
`define OFS_AUDIO_DAC_OFFSET      8'h69
`define OFS_CM_BALANCE            8'h6a
`define OFS_DC_PEAK_MONITOR       8'h6b
`define OFS_ENHANCEMENT_ENABLES   8'h6c

// ****************************************
// reset values
// ****************************************
`define RST_TIP_GAIN_MISMATCH     5'h10
`define RST_DIFF_DAC_GAIN         5'h11
`define RST_CM_DAC_GAIN           5'h11
`define RST_CURRENT_LIMIT_CAL     4'h8
`define RST_MONITOR_ADC_OFFSET    8'h88
`define RST_ANALOG_OFFSET_TRIM    4'h0
`define RST_AUDIO_DAC_OFFSET      8'h00
`define RST_CM_BALANCE            6'h20
`define RST_DC_PEAK_MONITOR       4'h8
`define RST_ENHANCEMENT_ENABLES   8'h00

// ****************************************
// enhancement field positions
// ****************************************
`define BIT_RING_END_BOOST        7
`define BIT_FAST_TONE_CLOCK       6
`define BIT_CONVERTER_SPEEDUP     5
`define BIT_EXT_IMPEDANCE_REF     4
`define BIT_BATT_SWITCH_DEBOUNCE  3
`define BIT_VOLTAGE_CLOSURE       2
`define BIT_CONVERTER_SQUELCH     1
`define BIT_CLOSURE_HYSTERESIS    0

// ****************************************
// analog trim field positions
// ****************************************
`define BIT_DAC_POS_TRIM          3
`define BIT_DAC_NEG_TRIM          2
`define BIT_ADC_POS_TRIM          1
`define BIT_ADC_NEG_TRIM          0

// ****************************************
// timing
// ****************************************
`define MCLK_HZ                   20000000
`define TONE_FAST_HZ              24000
`define TONE_SLOW_HZ              8000
`define CURRENT_BOOST_MA          41

// ****************************************
// indirect coefficient addresses
// ****************************************
`define FSK_COEF_FIRST_ADDR       8'h63
`define FSK_COEF_LAST_ADDR        8'h68
`define HYST_UPPER_ADDR           8'h1c
`define HYST_LOWER_ADDR           8'h2b

`endif

// File: calib_pkg.sv
package calib_pkg;

    typedef logic [7:0] reg_byte_type;

    typedef enum logic [1:0] {
        RATE_SLOW = 2'b01,
        RATE_FAST = 2'b10
    } tone_rate_type;

endpackage : calib_pkg

// File: cal_field.sv
`timescale 1ns/1ps
`default_nettype none

module cal_field #(
    parameter int          WIDTH     = 8,
    parameter logic [7:0]  RESET_VAL = 8'h00
) (
    input  wire logic             mclk,
    input  wire logic             srst,
    input  wire logic             sw_we,
    input  wire logic [WIDTH-1:0] sw_data,
    input  wire logic             hw_we,
    input  wire logic [WIDTH-1:0] hw_data,
    output logic      [WIDTH-1:0] value_q
);

    // a finishing calibration beats a same-cycle software write
    always_ff @(posedge mclk) begin
        if (srst) begin
            value_q <= RESET_VAL[WIDTH-1:0];
        end else if (hw_we) begin
            value_q <= hw_data;
        end else if (sw_we) begin
            value_q <= sw_data;
        end
    end

endmodule : cal_field

`default_nettype wire

// File: tone_clock_gen.sv
`timescale 1ns/1ps
`default_nettype none
`include "calib_params.svh"

module tone_clock_gen
    import calib_pkg::*;
(
    input  wire logic          mclk,
    input  wire logic          srst,
    input  wire tone_rate_type rate,
    output logic               tick_q
);

    // shortest period rounds down
    localparam int FAST_DIV = `MCLK_HZ / `TONE_FAST_HZ;
    localparam int SLOW_DIV = `MCLK_HZ / `TONE_SLOW_HZ;

    logic [11:0] count_q;
    logic [11:0] limit;

    assign limit = (rate == RATE_FAST) ? 12'(FAST_DIV - 1) : 12'(SLOW_DIV - 1);

    // restart the count on a rate change so a full new-rate period follows the change
    tone_rate_type rate_q;

    always_ff @(posedge mclk) begin
        if (srst) begin
            rate_q <= RATE_SLOW;
        end else begin
            rate_q <= rate;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || rate != rate_q || count_q >= limit) begin
            count_q <= 12'h000;
        end else begin
            count_q <= count_q + 12'h001;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            tick_q <= 1'b0;
        end else begin
            tick_q <= (rate == rate_q) && (count_q == limit);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    // a rate change spoils the period being timed, so only clean periods are checked
    logic [11:0] tick_gap_q;
    logic        period_clean_q;

    always_ff @(posedge mclk) begin
        if (srst || tick_q) begin
            tick_gap_q <= 12'h000;
        end else begin
            tick_gap_q <= tick_gap_q + 12'h001;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst || rate != rate_q) begin
            period_clean_q <= 1'b0;
        end else if (tick_q) begin
            period_clean_q <= 1'b1;
        end
    end

    AST_FAST_TICK_PERIOD: assert property (@(posedge mclk) disable iff (srst)
        tick_q && period_clean_q && rate == RATE_FAST |-> tick_gap_q == 12'(FAST_DIV - 1))
        else $error("fast tone period wrong");

    AST_SLOW_TICK_PERIOD: assert property (@(posedge mclk) disable iff (srst)
        tick_q && period_clean_q && rate == RATE_SLOW |-> tick_gap_q == 12'(SLOW_DIV - 1))
        else $error("slow tone period wrong");

endmodule : tone_clock_gen

`default_nettype wire

// File: calib_result_and_enhance_regs.sv
// Behaviour
// - tip mismatch result is five low bits, resets to 16, bits 7:5 read zero
// - differential gain result is five low bits, read/write, resets to 17
// - common-mode gain result is five low bits, read/write, resets to 17
// - current limit result is four low bits, read/write, resets to 8
// - monitor offset register holds two nibble results, each resetting to 8
// - analog trim holds four separate bits at 3..0, all reset clear
// - audio dac offset result fills all eight bits, resets to zero
// - balance result is six low bits, resets to 32, top two read zero
// - peak monitor result is the low nibble, resets to 8
// - enhancement register resets to zero, present only on later revisions
// - boost bit raises loop current limit to 41 mA after ring bursts
// - fast tone bit with fsk flag clocks tone one at 24 kHz, else 8 kHz
// - fast tone mode uses dedicated coefficients at indirect addresses 99 to 104
// - fast tone mode steps oscillator one cadence timers in 41.67 us ticks
// - speedup bit selects the multi-threshold converter control algorithm
// - speedup bit exists only on the on-chip converter variant
// - external reference bit disconnects the internal impedance resistor
// - voltage closure bit bases loop closure on tip-ring voltage
// - hysteresis bit applies upper and lower closure thresholds
// - squelch bit quiets converter noise on the on-chip converter variant
`timescale 1ns/1ps
`default_nettype none
`include "calib_params.svh"

module calib_result_and_enhance_regs
    import calib_pkg::*;
#(
    parameter bit          HAS_CONVERTER  = 1'b1,
    parameter bit          REV_C_OR_LATER = 1'b1,
    parameter int          LIMIT_WIDTH    = 5,
    parameter logic [4:0]  BOOST_LIMIT    = 5'h1f
) (
    input  wire logic                   mclk,
    input  wire logic                   srst,
    input  wire logic [7:0]             addr,
    input  wire logic [7:0]             wdata,
    input  wire logic                   wr_stb,
    input  wire logic                   rd_stb,
    output reg_byte_type                rdata_q,
    input  wire logic [8:0]             cal_load,
    input  wire logic [7:0]             cal_data,
    input  wire logic                   fsk_mode_flag,
    input  wire logic                   ring_end_window,
    input  wire logic [LIMIT_WIDTH-1:0] programmed_current_limit,
    output logic [4:0]                  tip_mismatch_value,
    output logic [4:0]                  diff_gain_value,
    output logic [4:0]                  cm_gain_value,
    output logic [3:0]                  current_limit_trim,
    output logic [3:0]                  monitor_offset_first,
    output logic [3:0]                  monitor_offset_second,
    output logic                        dac_pos_trim,
    output logic                        dac_neg_trim,
    output logic                        adc_pos_trim,
    output logic                        adc_neg_trim,
    output logic [7:0]                  audio_dac_offset_value,
    output logic [5:0]                  longitudinal_balance_value,
    output logic [3:0]                  peak_monitor_trim,
    output logic [LIMIT_WIDTH-1:0]      loop_current_limit_q,
    output logic                        tone_osc_one_tick,
    output logic                        tone_fast_active,
    output logic [7:0]                  osc_coef_base_addr,
    output logic                        cadence_tick,
    output logic                        converter_speedup,
    output logic                        external_impedance_reference,
    output logic                        battery_switch_debounce,
    output logic                        voltage_based_closure,
    output logic                        converter_noise_squelch,
    output logic                        closure_hysteresis_enable,
    output logic [7:0]                  hyst_upper_addr,
    output logic [7:0]                  hyst_lower_addr
);

    // ****************************************
    // decode helpers
    // ****************************************
    localparam logic [7:0] STD_COEF_ADDR = 8'h00;

    // converter-only bits vanish on the external-battery variant
    localparam logic [7:0] ENH_MASK =
        (!REV_C_OR_LATER) ? 8'h00 :
        HAS_CONVERTER ? 8'hf7 : 8'hdd;

    function automatic logic [3:0] reg_index(input logic [7:0] a);
        logic [3:0] idx;
        idx = 4'hf;
        if (a >= `OFS_TIP_GAIN_MISMATCH && a <= `OFS_ENHANCEMENT_ENABLES) begin
            idx = 4'(a - `OFS_TIP_GAIN_MISMATCH);
        end
        return idx;
    endfunction : reg_index

    logic [3:0]  wr_idx;
    logic [3:0]  rd_idx;
    logic [9:0]  sw_we;

    assign wr_idx = reg_index(addr);
    assign rd_idx = wr_idx;

    always_comb begin
        sw_we = '0;
        if (wr_stb && wr_idx <= 4'h9) begin
            sw_we[wr_idx] = 1'b1;
        end
    end

    // ****************************************
    // calibration result fields
    // ****************************************
    cal_field #(.WIDTH(5), .RESET_VAL({3'h0, `RST_TIP_GAIN_MISMATCH})) u_tip (
        .mclk    (mclk),
        .srst    (srst),
        .sw_we   (sw_we[0]),
        .sw_data (wdata[4:0]),
        .hw_we   (cal_load[0]),
        .hw_data (cal_data[4:0]),
        .value_q (tip_mismatch_value)
    );

    cal_field #(.WIDTH(5), .RESET_VAL({3'h0, `RST_DIFF_DAC_GAIN})) u_diff (
        .mclk    (mclk),
        .srst    (srst),
        .sw_we   (sw_we[1]),
        .sw_data (wdata[4:0]),
        .hw_we   (cal_load[1]),
        .hw_data (cal_data[4:0]),
        .value_q (diff_gain_value)
    );

    cal_field #(.WIDTH(5), .RESET_VAL({3'h0, `RST_CM_DAC_GAIN})) u_cm (
        .mclk    (mclk),
        .srst    (srst),
        .sw_we   (sw_we[2]),
        .sw_data (wdata[4:0]),
        .hw_we   (cal_load[2]),
        .hw_data (cal_data[4:0]),
        .value_q (cm_gain_value)
    );

    cal_field #(.WIDTH(4), .RESET_VAL({4'h0, `RST_CURRENT_LIMIT_CAL})) u_programmed_current_limit (
        .mclk    (mclk),
        .srst    (srst),
        .sw_we   (sw_we[3]),
        .sw_data (wdata[3:0]),
        .hw_we   (cal_load[3]),
        .hw_data (cal_data[3:0]),
        .value_q (current_limit_trim)
    );

    logic [7:0] monitor_q;

    cal_field #(.WIDTH(8), .RESET_VAL(`RST_MONITOR_ADC_OFFSET)) u_mon (
        .mclk    (mclk),
        .srst    (srst),
        .sw_we   (sw_we[4]),
        .sw_data (wdata),
        .hw_we   (cal_load[4]),
        .hw_data (cal_data),
        .value_q (monitor_q)
    );

    assign monitor_offset_first  = monitor_q[7:4];
    assign monitor_offset_second = monitor_q[3:0];

    logic [3:0] trim_q;

    cal_field #(.WIDTH(4), .RESET_VAL({4'h0, `RST_ANALOG_OFFSET_TRIM})) u_trim (
        .mclk    (mclk),
        .srst    (srst),
        .sw_we   (sw_we[5]),
        .sw_data (wdata[3:0]),
        .hw_we   (cal_load[5]),
        .hw_data (cal_data[3:0]),
        .value_q (trim_q)
    );

    assign dac_pos_trim = trim_q[`BIT_DAC_POS_TRIM];
    assign dac_neg_trim = trim_q[`BIT_DAC_NEG_TRIM];
    assign adc_pos_trim = trim_q[`BIT_ADC_POS_TRIM];
    assign adc_neg_trim = trim_q[`BIT_ADC_NEG_TRIM];

    cal_field #(.WIDTH(8), .RESET_VAL(`RST_AUDIO_DAC_OFFSET)) u_audio_dac_offset_value (
        .mclk    (mclk),
        .srst    (srst),
        .sw_we   (sw_we[6]),
        .sw_data (wdata),
        .hw_we   (cal_load[6]),
        .hw_data (cal_data),
        .value_q (audio_dac_offset_value)
    );

    cal_field #(.WIDTH(6), .RESET_VAL({2'h0, `RST_CM_BALANCE})) u_bal (
        .mclk    (mclk),
        .srst    (srst),
        .sw_we   (sw_we[7]),
        .sw_data (wdata[5:0]),
        .hw_we   (cal_load[7]),
        .hw_data (cal_data[5:0]),
        .value_q (longitudinal_balance_value)
    );

    cal_field #(.WIDTH(4), .RESET_VAL({4'h0, `RST_DC_PEAK_MONITOR})) u_peak (
        .mclk    (mclk),
        .srst    (srst),
        .sw_we   (sw_we[8]),
        .sw_data (wdata[3:0]),
        .hw_we   (cal_load[8]),
        .hw_data (cal_data[3:0]),
        .value_q (peak_monitor_trim)
    );

    // ****************************************
    // enhancement enables
    // ****************************************
    logic [7:0] enh_q;

    // unimplemented bits never store, so they read zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            enh_q <= `RST_ENHANCEMENT_ENABLES;
        end else if (sw_we[9]) begin
            enh_q <= wdata & ENH_MASK;
        end
    end

    assign converter_speedup            = enh_q[`BIT_CONVERTER_SPEEDUP];
    assign external_impedance_reference = enh_q[`BIT_EXT_IMPEDANCE_REF];
    assign battery_switch_debounce      = enh_q[`BIT_BATT_SWITCH_DEBOUNCE];
    assign voltage_based_closure        = enh_q[`BIT_VOLTAGE_CLOSURE];
    assign converter_noise_squelch      = enh_q[`BIT_CONVERTER_SQUELCH];
    assign closure_hysteresis_enable    = enh_q[`BIT_CLOSURE_HYSTERESIS];
    assign hyst_upper_addr              = `HYST_UPPER_ADDR;
    assign hyst_lower_addr              = `HYST_LOWER_ADDR;

    // ****************************************
    // current limit boost
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst) begin
            loop_current_limit_q <= '0;
        end else if (enh_q[`BIT_RING_END_BOOST] && ring_end_window) begin
            loop_current_limit_q <= LIMIT_WIDTH'(BOOST_LIMIT);
        end else begin
            loop_current_limit_q <= programmed_current_limit;
        end
    end

    // ****************************************
    // tone generator one clocking
    // ****************************************
    tone_rate_type tone_rate;

    assign tone_fast_active = enh_q[`BIT_FAST_TONE_CLOCK] && fsk_mode_flag;
    assign tone_rate        = tone_fast_active ? RATE_FAST : RATE_SLOW;

    tone_clock_gen u_tone (
        .mclk   (mclk),
        .srst   (srst),
        .rate   (tone_rate),
        .tick_q (tone_osc_one_tick)
    );

    // dedicated coefficients only while the fast clock runs
    assign osc_coef_base_addr = tone_fast_active ? `FSK_COEF_FIRST_ADDR : STD_COEF_ADDR;
    // cadence timers share the tone tick, so fast mode gives 41.67 us steps
    assign cadence_tick = tone_osc_one_tick;

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge mclk) begin
        if (srst || !rd_stb) begin
            rdata_q <= 8'h00;
        end else begin
            case (rd_idx)
                4'h0:    rdata_q <= {3'h0, tip_mismatch_value};
                4'h1:    rdata_q <= {3'h0, diff_gain_value};
                4'h2:    rdata_q <= {3'h0, cm_gain_value};
                4'h3:    rdata_q <= {4'h0, current_limit_trim};
                4'h4:    rdata_q <= monitor_q;
                4'h5:    rdata_q <= {4'h0, trim_q};
                4'h6:    rdata_q <= audio_dac_offset_value;
                4'h7:    rdata_q <= {2'h0, longitudinal_balance_value};
                4'h8:    rdata_q <= {4'h0, peak_monitor_trim};
                4'h9:    rdata_q <= enh_q;
                default: rdata_q <= 8'h00;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence write_to(logic [7:0] a);
        wr_stb && addr == a && cal_load == 9'h000;
    endsequence

    sequence read_of(logic [7:0] a);
        rd_stb && addr == a;
    endsequence

    AST_RESET_VALUES: assert property (@(posedge mclk)
        srst ##1 !srst |-> tip_mismatch_value == 5'h10 && diff_gain_value == 5'h11
            && cm_gain_value == 5'h11 && current_limit_trim == 4'h8
            && monitor_q == 8'h88 && longitudinal_balance_value == 6'h20
            && peak_monitor_trim == 4'h8 && enh_q == 8'h00 && trim_q == 4'h0)
        else $error("reset values wrong");

    AST_TIP_READ_UPPER_ZERO: assert property (@(posedge mclk) disable iff (srst)
        read_of(`OFS_TIP_GAIN_MISMATCH) |=> rdata_q[7:5] == 3'h0
            && rdata_q[4:0] == $past(tip_mismatch_value))
        else $error("tip result read wrong");

    AST_DIFF_WRITE_READBACK: assert property (@(posedge mclk) disable iff (srst)
        write_to(`OFS_DIFF_DAC_GAIN) ##1 read_of(`OFS_DIFF_DAC_GAIN)
            |=> rdata_q == {3'h0, $past(wdata, 2) & 8'h1f})
        else $error("diff gain readback wrong");

    AST_BALANCE_TOP_ZERO: assert property (@(posedge mclk) disable iff (srst)
        read_of(`OFS_CM_BALANCE) |=> rdata_q[7:6] == 2'h0)
        else $error("balance upper bits not zero");

    AST_MONITOR_NIBBLES: assert property (@(posedge mclk) disable iff (srst)
        write_to(`OFS_MONITOR_ADC_OFFSET) |=> monitor_offset_first == $past(wdata[7:4])
            && monitor_offset_second == $past(wdata[3:0]))
        else $error("monitor nibbles wrong");

    AST_HW_LOAD_WINS: assert property (@(posedge mclk) disable iff (srst)
        cal_load[7] |=> longitudinal_balance_value == $past(cal_data[5:0]))
        else $error("calibration load lost");

    AST_REVISION_ABSENT: assert property (@(posedge mclk) disable iff (srst)
        write_to(`OFS_ENHANCEMENT_ENABLES) |=> enh_q[7:6]
            == (REV_C_OR_LATER ? $past(wdata[7:6]) : 2'h0))
        else $error("enhancement present on early revision");

    AST_CONVERTER_BITS: assert property (@(posedge mclk) disable iff (srst)
        HAS_CONVERTER ? !battery_switch_debounce
            : (!converter_speedup && !converter_noise_squelch))
        else $error("unimplemented enhancement bit set");

    AST_BOOST_LIMIT: assert property (@(posedge mclk) disable iff (srst)
        enh_q[`BIT_RING_END_BOOST] && ring_end_window |=> loop_current_limit_q
            == LIMIT_WIDTH'(BOOST_LIMIT))
        else $error("boost limit not applied");

    AST_NO_BOOST: assert property (@(posedge mclk) disable iff (srst)
        !enh_q[`BIT_RING_END_BOOST] |=> loop_current_limit_q
            == $past(programmed_current_limit))
        else $error("programmed limit not used");

    AST_COEF_SELECT: assert property (@(posedge mclk) disable iff (srst)
        osc_coef_base_addr == (tone_fast_active ? 8'h63 : 8'h00))
        else $error("coefficient set wrong");

    AST_CLOSURE_SELECT: assert property (@(posedge mclk) disable iff (srst)
        write_to(`OFS_ENHANCEMENT_ENABLES) |=> voltage_based_closure
            == ($past(wdata[2]) && REV_C_OR_LATER)
            && closure_hysteresis_enable == ($past(wdata[0]) && REV_C_OR_LATER))
        else $error("closure select wrong");

endmodule : calib_result_and_enhance_regs

`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic       mclk, srst, wr_stb, rd_stb, fsk_mode_flag, ring_end_window;
    logic [7:0] addr, wdata, rdata_q, cal_data, audio_dac_offset_value;
    logic [7:0] osc_coef_base_addr, hyst_upper_addr, hyst_lower_addr;
    logic [8:0] cal_load;
    logic [4:0] programmed_current_limit, loop_current_limit_q;
    logic [4:0] tip_mismatch_value, diff_gain_value, cm_gain_value;
    logic [3:0] current_limit_trim, monitor_offset_first, monitor_offset_second;
    logic [3:0] peak_monitor_trim;
    logic [5:0] longitudinal_balance_value;
    logic       dac_pos_trim, dac_neg_trim, adc_pos_trim, adc_neg_trim;
    logic       tone_osc_one_tick, tone_fast_active, cadence_tick;
    logic       converter_speedup, external_impedance_reference;
    logic       battery_switch_debounce, voltage_based_closure;
    logic       converter_noise_squelch, closure_hysteresis_enable;
    int         comparisons, n_fail, n;
    // converter variant: bit 3 of the enable byte is not kept
    logic [7:0] rstv [10] = '{8'h10, 8'h11, 8'h11, 8'h08, 8'h88,
                              8'h00, 8'h00, 8'h20, 8'h08, 8'h00};
    logic [7:0] mask [10] = '{8'h1f, 8'h1f, 8'h1f, 8'h0f, 8'hff,
                              8'h0f, 8'hff, 8'h3f, 8'h0f, 8'hf7};

    calib_result_and_enhance_regs calib_result_and_enhance_regs_i (.*);

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ****************************************
    // access and compare tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic chk_n(input int got, input int exp, input string m);
        comparisons++;
        if (got != exp) begin
            n_fail++;
            $display("CHECK FAILED %0t %s got %0d exp %0d", $time, m, got, exp);
        end
    endtask : chk_n

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        #1;
    endtask : wr

    // write then read with no idle cycle between the strobes
    task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp,
                         input string m);
        @(posedge mclk);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge mclk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 chk(rdata_q, exp, m);
    endtask : wr_rd

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string m);
        @(posedge mclk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge mclk);
        rd_stb <= 1'b0;
        #1 chk(rdata_q, exp, m);
    endtask : rchk

    task automatic settle(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask : settle

    // first tick may follow a divider restart, so callers take a later gap
    task automatic gap(input bit cad, output int g);
        int k;
        k = 0;
        g = 0;
        while ((cad ? cadence_tick : tone_osc_one_tick) !== 1'b1 && k < 3000) begin
            @(posedge mclk);
            #1 k++;
        end
        do begin
            @(posedge mclk);
            #1 g++;
        end while ((cad ? cadence_tick : tone_osc_one_tick) !== 1'b1 && g < 3000);
    endtask : gap

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (30000) @(posedge mclk);
        n_fail++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        report_and_stop;
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        srst = 1'b1; addr = 8'h00; wdata = 8'h00; wr_stb = 1'b0; rd_stb = 1'b0;
        cal_load = 9'h000; cal_data = 8'h00; fsk_mode_flag = 1'b0;
        ring_end_window = 1'b0; programmed_current_limit = 5'h03;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        for (int i = 0; i < 10; i++) rchk(8'h63 + i, rstv[i], "reset");
        $display("test reset_values done");
        for (int i = 0; i < 10; i++) begin
            wr_rd(8'h63 + i, 8'hff, mask[i], "ones");
            wr_rd(8'h63 + i, 8'h00, 8'h00, "zeros");
        end
        chk(tip_mismatch_value | diff_gain_value | cm_gain_value, 8'h00, "gains");
        chk(current_limit_trim | peak_monitor_trim, 8'h00, "trims");
        wr(8'h6d, 8'hff);
        rchk(8'h6d, 8'h00, "unmapped");
        rchk(8'h62, 8'h00, "below map");
        $display("test masks done");
        wr(8'h67, 8'ha5);
        chk({monitor_offset_first, monitor_offset_second}, 8'ha5, "nibbles");
        wr(8'h68, 8'h0a);
        chk({4'h0, dac_pos_trim, dac_neg_trim, adc_pos_trim, adc_neg_trim}, 8'h0a, "trim");
        wr(8'h69, 8'h5a);
        chk(audio_dac_offset_value, 8'h5a, "dac offset");
        // hardware load and software write meet in the same cycle
        @(posedge mclk);
        addr <= 8'h63; wdata <= 8'h1e; wr_stb <= 1'b1; cal_load <= 9'h181; cal_data <= 8'hfb;
        @(posedge mclk);
        wr_stb <= 1'b0; cal_load <= 9'h000;
        rchk(8'h63, 8'h1b, "load wins");
        chk({4'h0, peak_monitor_trim}, 8'h0b, "peak load");
        chk({2'h0, longitudinal_balance_value}, 8'h3b, "balance load");
        $display("test fields done");
        wr(8'h6c, 8'h3f);
        chk({2'h0, converter_speedup, external_impedance_reference, battery_switch_debounce,
             voltage_based_closure, converter_noise_squelch, closure_hysteresis_enable},
            8'h37, "enables");
        chk(hyst_upper_addr, 8'h1c, "hyst up");
        chk(hyst_lower_addr, 8'h2b, "hyst low");
        wr(8'h6c, 8'h80);
        settle(2);
        chk({3'h0, loop_current_limit_q}, 8'h03, "no window");
        @(posedge mclk) ring_end_window <= 1'b1;
        settle(2);
        chk({3'h0, loop_current_limit_q}, 8'h1f, "boost");
        wr(8'h6c, 8'h00);
        settle(2);
        chk({3'h0, loop_current_limit_q}, 8'h03, "boost off");
        $display("test enhancement done");
        wr(8'h6c, 8'h40);
        settle(1);
        chk({7'h0, tone_fast_active}, 8'h00, "flag low");
        chk(osc_coef_base_addr, 8'h00, "std coef");
        gap(1'b0, n);
        gap(1'b0, n);
        chk_n(n, 2500, "slow period");
        @(posedge mclk) fsk_mode_flag <= 1'b1;
        settle(1);
        chk({7'h0, tone_fast_active}, 8'h01, "fast");
        chk(osc_coef_base_addr, 8'h63, "fsk coef");
        gap(1'b0, n);
        gap(1'b0, n);
        chk_n(n, 833, "fast period");
        gap(1'b1, n);
        chk_n(n, 833, "cadence step");
        $display("test tone done");
        report_and_stop;
    end
endmodule : tb

`default_nettype wire
